// ==== src/bkr_defs.svh ====
// register map, field positions, reset values and timing for the braking sequencer
`ifndef BKR_DEFS_SVH
`define BKR_DEFS_SVH
// ==========================================
// register byte offsets
`define BKR_OFS_CTRL 12'h000
`define BKR_OFS_FREQ 12'h004
`define BKR_OFS_FMAX 12'h008
`define BKR_OFS_CURR 12'h00C
`define BKR_OFS_TSTOP 12'h010
`define BKR_OFS_TSTART 12'h014
`define BKR_OFS_TMISC 12'h018
`define BKR_OFS_DIFN0 12'h01C
`define BKR_OFS_DIFN1 12'h020
`define BKR_OFS_AIFN 12'h024
`define BKR_OFS_STAT 12'h028
// ==========================================
// writable bit masks, reserved bits read zero
`define BKR_MSK_CTRL 32'h0000_0137
`define BKR_MSK_FREQ 32'hFFFF_FFFF
`define BKR_MSK_FMAX 32'h0000_FFFF
`define BKR_MSK_CURR 32'h0FFF_FFFF
`define BKR_MSK_TIME 32'hFFFF_FFFF
`define BKR_MSK_DIFN 32'hFFFF_FFFF
`define BKR_MSK_AIFN 32'h0000_FFFF
// ==========================================
// field positions
`define BKR_CTRL_MODE 2:0
`define BKR_CTRL_STOP 5:4
`define BKR_CTRL_PM 8
`define BKR_LO16 15:0
`define BKR_HI16 31:16
`define BKR_CURR_DC 7:0
`define BKR_CURR_MOTOR 15:8
`define BKR_CURR_SC 27:16
// ==========================================
// codes and limits
`define BKR_MODE_PM_SENSORLESS_CONTROL 3'h5
`define BKR_MODE_SLV 3'h2
`define BKR_FN_DCBRAKE 8'h21
`define BKR_FN_SCBRAKE 8'h41
`define BKR_AFN_DCCURR 8'h05
`define BKR_DC_MAX 8'h64
`define BKR_SC_MAX 12'h7D0
`define BKR_RST_FMAX 32'h0000_0258
`define BKR_RST_CURR 32'h0000_6432
`define BKR_RST_TMISC 32'h0064_0005
// ==========================================
// timing: one tick is 10 ms at 250 MHz
`define BKR_TICK_US 10000
`define BKR_CLK_MHZ 250
`define BKR_TICK_CYC (`BKR_TICK_US * `BKR_CLK_MHZ)
`define BKR_TENTHS_TICKS 10
`endif

// ==== src/bkr_pkg.sv ====
// types shared by the braking sequencer modules
package bkr_pkg;
  typedef enum logic [3:0] {
    BKR_IDLE, BKR_START_SC, BKR_START_DC, BKR_RUN, BKR_DECEL,
    BKR_STOP_SC, BKR_STOP_DC, BKR_BB_WAIT, BKR_COAST_WAIT, BKR_EXT_BRAKE
  } bkr_state_t;
  typedef struct packed {
    logic [23:0] cnt;
  } bkr_tmr_st_t;
endpackage

// ==== src/bkr_tmr_if.sv ====
// link between the sequencer and its phase timer
`timescale 1ns/1ns
interface bkr_tmr_if;
  logic load;
  logic [23:0] count;
  logic tick;
  logic done;
  modport seq (output load, output count, output tick, input done);
  modport tmr (input load, input count, input tick, output done);
endinterface // bkr_tmr_if

// ==== src/bkr_phase_timer.sv ====
// down counter in 10 ms ticks timing one braking phase
`timescale 1ns/1ns
module bkr_phase_timer
  import bkr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  bkr_tmr_if.tmr t
);
  bkr_tmr_st_t s_r;
  bkr_tmr_st_t s_nxt;
  // ==========================================
  // count
  always_comb
  begin
    s_nxt = s_r;
    if (t.load)
      s_nxt.cnt = t.count;
    else if (t.tick && s_r.cnt != 24'h00_0000)
      s_nxt.cnt = s_r.cnt - 24'h00_0001;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign t.done = (s_r.cnt == 24'h00_0000);
endmodule // bkr_phase_timer

// ==== src/bkr_seq.sv ====
// stop mode and start/stop braking sequencer with apb registers
// ==========================================
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "bkr_defs.svh"
module bkr_seq
  import bkr_pkg::*;
#(
  parameter int TICK_CYCLES = `BKR_TICK_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_pin,
  input wire logic [7:0] di_pin,
  input wire logic [15:0] out_freq,
  input wire logic [9:0] ai1_code,
  input wire logic [9:0] ai2_code,
  output logic baseblock,
  output logic dc_brake,
  output logic sc_brake,
  output logic [7:0] dc_level,
  output logic [11:0] sc_level,
  output logic run_enable,
  output logic speed_search,
  output logic start_at_min,
  output logic [23:0] ramp_ticks
);
  typedef struct packed {
    bkr_state_t st;
    bkr_state_t after_bb;
    logic run_s1;
    logic run_s2;
    logic [7:0] di_s1;
    logic [7:0] di_s2;
    logic [15:0] f_stop;
    logic [23:0] coast_ticks;
    logic [21:0] div_cnt;
    logic [31:0] ctrl;
    logic [31:0] freq;
    logic [31:0] fmax;
    logic [31:0] curr;
    logic [31:0] tstop;
    logic [31:0] tstart;
    logic [31:0] tmisc;
    logic [31:0] difn0;
    logic [31:0] difn1;
    logic [31:0] aifn;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic baseblock;
    logic dc_brake;
    logic sc_brake;
    logic [7:0] dc_level;
    logic [11:0] sc_level;
    logic run_enable;
    logic speed_search;
    logic start_at_min;
    logic [23:0] ramp_ticks;
  } bkr_seq_st_t;
  bkr_seq_st_t s_r;
  bkr_seq_st_t s_nxt;
  bkr_tmr_if tif ();
  bkr_phase_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .t(tif.tmr)
  );
  logic is_pm;
  logic [15:0] fmin;
  logic [15:0] brk_freq;
  logic [15:0] fmax_nz;
  logic di_dc_req;
  logic di_sc_req;
  logic [7:0] dc_set;
  logic [7:0] dc_eff;
  logic [11:0] sc_eff;
  logic dc_ok;
  logic [15:0] t_dc_stop;
  logic [15:0] t_dc_start;
  logic [15:0] t_sc_stop;
  logic [15:0] t_sc_start;
  logic [23:0] t_bb;
  logic [31:0] dcdb_prod;
  logic [31:0] dcdb_q;
  logic [31:0] ramp_prod;
  logic [31:0] ramp_q;
  logic [6:0] ai1_pct;
  logic [6:0] ai2_pct;
  logic [16:0] ai1_mul;
  logic [16:0] ai2_mul;
  logic wr;
  logic rd;
  // ==========================================
  // configuration decode
  always_comb
  begin
    is_pm = (s_r.ctrl[`BKR_CTRL_MODE] == `BKR_MODE_PM_SENSORLESS_CONTROL);
    fmin = s_r.freq[`BKR_HI16];
    brk_freq = (s_r.freq[`BKR_LO16] < fmin) ? fmin : s_r.freq[`BKR_LO16];
    fmax_nz = (s_r.fmax[`BKR_LO16] == 16'h0000) ? 16'h0001 : s_r.fmax[`BKR_LO16];
    t_dc_stop = (s_r.tstop[`BKR_LO16] > 16'h03E8) ? 16'h03E8 : s_r.tstop[`BKR_LO16];
    t_sc_stop = (s_r.tstop[`BKR_HI16] > 16'h2710) ? 16'h2710 : s_r.tstop[`BKR_HI16];
    t_sc_start = (s_r.tstart[`BKR_HI16] > 16'h2710) ? 16'h2710 : s_r.tstart[`BKR_HI16];
    t_dc_start = (s_r.tstart[`BKR_LO16] > 16'h2710) ? 16'h2710 : s_r.tstart[`BKR_LO16];
    t_bb = 24'(s_r.tmisc[`BKR_LO16]) * 24'(`BKR_TENTHS_TICKS);
    di_dc_req = 1'b0;
    di_sc_req = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      di_dc_req |= s_r.di_s2[i] && s_r.difn0[i*8 +: 8] == `BKR_FN_DCBRAKE;
      di_dc_req |= s_r.di_s2[i+4] && s_r.difn1[i*8 +: 8] == `BKR_FN_DCBRAKE;
      di_sc_req |= s_r.di_s2[i] && s_r.difn0[i*8 +: 8] == `BKR_FN_SCBRAKE;
      di_sc_req |= s_r.di_s2[i+4] && s_r.difn1[i*8 +: 8] == `BKR_FN_SCBRAKE;
    end
    ai1_mul = 17'(ai1_code) * 17'h0_0064;
    ai2_mul = 17'(ai2_code) * 17'h0_0064;
    ai1_pct = ai1_mul[16:10];
    ai2_pct = ai2_mul[16:10];
    dc_set = s_r.curr[`BKR_CURR_DC];
    if (s_r.aifn[7:0] == `BKR_AFN_DCCURR)
      dc_set = {1'b0, ai1_pct};
    else if (s_r.aifn[15:8] == `BKR_AFN_DCCURR)
      dc_set = {1'b0, ai2_pct};
    dc_eff = (dc_set > `BKR_DC_MAX) ? `BKR_DC_MAX : dc_set;
    if (dc_eff > s_r.curr[`BKR_CURR_MOTOR])
      dc_eff = s_r.curr[`BKR_CURR_MOTOR];
    sc_eff = (s_r.curr[`BKR_CURR_SC] > `BKR_SC_MAX) ? `BKR_SC_MAX : s_r.curr[`BKR_CURR_SC];
    dc_ok = (dc_eff != 8'h00);
    dcdb_prod = 32'(t_dc_stop) * 32'd10 * 32'(s_r.f_stop);
    dcdb_q = dcdb_prod / 32'(fmax_nz);
    ramp_prod = 32'(s_r.tmisc[`BKR_HI16]) * 32'(`BKR_TENTHS_TICKS) * 32'(out_freq);
    ramp_q = ramp_prod / 32'(fmax_nz);
  end
  // ==========================================
  // sequencer, apb and registers
  always_comb
  begin
    s_nxt = s_r;
    tif.load = 1'b0;
    tif.count = 24'h00_0000;
    s_nxt.run_s1 = run_pin;
    s_nxt.run_s2 = s_r.run_s1;
    s_nxt.di_s1 = di_pin;
    s_nxt.di_s2 = s_r.di_s1;
    // 10 ms tick, restarted on every timer load
    tif.tick = (s_r.div_cnt == 22'(TICK_CYCLES - 1));
    s_nxt.div_cnt = tif.tick ? 22'h00_0000 : s_r.div_cnt + 22'h00_0001;
    s_nxt.ramp_ticks = (ramp_q > 32'h00FF_FFFF) ? 24'hFF_FFFF : ramp_q[23:0];
    s_nxt.dc_level = dc_eff;
    s_nxt.sc_level = sc_eff;
    case (s_r.st)
      BKR_IDLE:
      begin
        s_nxt.baseblock = 1'b1;
        s_nxt.dc_brake = 1'b0;
        s_nxt.sc_brake = 1'b0;
        s_nxt.run_enable = 1'b0;
        s_nxt.start_at_min = (t_dc_start == 16'h0000) || (is_pm && t_sc_stop == 16'h0000);
        if (s_r.run_s2)
        begin
          if (is_pm && t_sc_start != 16'h0000)
          begin
            s_nxt.st = BKR_START_SC;
            tif.load = 1'b1;
            tif.count = 24'(t_sc_start);
          end
          else if (dc_ok && t_dc_start != 16'h0000)
          begin
            s_nxt.st = BKR_START_DC;
            tif.load = 1'b1;
            tif.count = 24'(t_dc_start);
          end
          else
            s_nxt.st = BKR_RUN;
        end
        else if (di_dc_req || (di_sc_req && is_pm))
          s_nxt.st = BKR_EXT_BRAKE;
      end
      BKR_EXT_BRAKE:
      begin
        s_nxt.sc_brake = di_sc_req && is_pm;
        s_nxt.dc_brake = di_dc_req && !(di_sc_req && is_pm);
        s_nxt.baseblock = 1'b0;
        if (!(di_dc_req || (di_sc_req && is_pm)) || s_r.run_s2)
          s_nxt.st = BKR_IDLE;
      end
      BKR_START_SC:
      begin
        s_nxt.baseblock = 1'b0;
        s_nxt.sc_brake = 1'b1;
        if (tif.done)
        begin
          if (dc_ok && t_dc_start != 16'h0000)
          begin
            s_nxt.st = BKR_START_DC;
            tif.load = 1'b1;
            tif.count = 24'(t_dc_start);
          end
          else
            s_nxt.st = BKR_RUN;
        end
      end
      BKR_START_DC:
      begin
        s_nxt.baseblock = 1'b0;
        s_nxt.sc_brake = 1'b0;
        s_nxt.dc_brake = 1'b1;
        if (tif.done)
          s_nxt.st = BKR_RUN;
      end
      BKR_RUN:
      begin
        s_nxt.baseblock = 1'b0;
        s_nxt.dc_brake = 1'b0;
        s_nxt.sc_brake = 1'b0;
        s_nxt.run_enable = 1'b1;
        if (s_r.run_s2)
          s_nxt.speed_search = 1'b0;
        else
        begin
          s_nxt.f_stop = out_freq;
          case (is_pm ? 2'd0 : s_r.ctrl[`BKR_CTRL_STOP])
            2'd0: s_nxt.st = BKR_DECEL;
            default:
            begin
              s_nxt.st = BKR_BB_WAIT;
              s_nxt.run_enable = 1'b0;
              tif.load = 1'b1;
              tif.count = t_bb;
              s_nxt.after_bb = (s_r.ctrl[`BKR_CTRL_STOP] == 2'd2) ? BKR_STOP_DC :
                               (s_r.ctrl[`BKR_CTRL_STOP] == 2'd3) ? BKR_COAST_WAIT : BKR_IDLE;
              s_nxt.coast_ticks = s_nxt.ramp_ticks;
              if (s_r.ctrl[`BKR_CTRL_MODE] == `BKR_MODE_SLV)
                s_nxt.speed_search = 1'b1;
            end
          endcase
        end
      end
      BKR_DECEL:
      begin
        if (s_r.run_s2)
          s_nxt.st = BKR_RUN;
        else if (out_freq <= brk_freq)
        begin
          s_nxt.run_enable = 1'b0;
          if (is_pm && t_sc_stop != 16'h0000)
          begin
            s_nxt.st = BKR_STOP_SC;
            tif.load = 1'b1;
            tif.count = 24'(t_sc_stop);
          end
          else if (dc_ok && t_dc_stop != 16'h0000)
          begin
            s_nxt.st = BKR_STOP_DC;
            tif.load = 1'b1;
            tif.count = 24'(t_dc_stop);
          end
          else
            s_nxt.st = BKR_IDLE;
        end
      end
      BKR_STOP_SC:
      begin
        s_nxt.sc_brake = 1'b1;
        if (tif.done)
        begin
          s_nxt.sc_brake = 1'b0;
          if (dc_ok && t_dc_stop != 16'h0000)
          begin
            s_nxt.st = BKR_STOP_DC;
            tif.load = 1'b1;
            tif.count = 24'(t_dc_stop);
          end
          else
            s_nxt.st = BKR_IDLE;
        end
      end
      BKR_STOP_DC:
      begin
        s_nxt.baseblock = 1'b0;
        s_nxt.dc_brake = 1'b1;
        if (tif.done)
          s_nxt.st = BKR_IDLE;
      end
      BKR_BB_WAIT:
      begin
        s_nxt.baseblock = 1'b1;
        if (tif.done)
        begin
          s_nxt.st = s_r.after_bb;
          if (s_r.after_bb == BKR_STOP_DC)
          begin
            tif.load = 1'b1;
            tif.count = (dcdb_q > 32'h00FF_FFFF) ? 24'hFF_FFFF : dcdb_q[23:0];
            if (!dc_ok || dcdb_q == 32'h0000_0000 || s_r.f_stop == 16'h0000)
              s_nxt.st = BKR_IDLE;
          end
          else if (s_r.after_bb == BKR_COAST_WAIT)
          begin
            tif.load = 1'b1;
            tif.count = s_r.coast_ticks;
          end
        end
      end
      BKR_COAST_WAIT:
      begin
        s_nxt.baseblock = 1'b1;
        if (tif.done)
          s_nxt.st = BKR_IDLE;
      end
      default: s_nxt.st = BKR_IDLE;
    endcase
    // restart the tick on load so a phase never runs a tick short
    if (tif.load)
      s_nxt.div_cnt = 22'h00_0000;
    // ==========================================
    // apb slave, zero wait: answer prepared in setup cycle
    wr = psel && !penable && pwrite;
    rd = psel && !penable && !pwrite;
    s_nxt.pready = psel && !penable;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = 32'h0000_0000;
    if (psel && !penable)
    begin
      case (paddr)
        `BKR_OFS_CTRL: s_nxt.prdata = s_r.ctrl;
        `BKR_OFS_FREQ: s_nxt.prdata = s_r.freq;
        `BKR_OFS_FMAX: s_nxt.prdata = s_r.fmax;
        `BKR_OFS_CURR: s_nxt.prdata = s_r.curr;
        `BKR_OFS_TSTOP: s_nxt.prdata = s_r.tstop;
        `BKR_OFS_TSTART: s_nxt.prdata = s_r.tstart;
        `BKR_OFS_TMISC: s_nxt.prdata = s_r.tmisc;
        `BKR_OFS_DIFN0: s_nxt.prdata = s_r.difn0;
        `BKR_OFS_DIFN1: s_nxt.prdata = s_r.difn1;
        `BKR_OFS_AIFN: s_nxt.prdata = s_r.aifn;
        `BKR_OFS_STAT: s_nxt.prdata = {16'h0000, s_r.speed_search, s_r.start_at_min, s_r.run_enable,
                                       s_r.sc_brake, s_r.dc_brake, s_r.baseblock, 6'h00, 4'(s_r.st)};
        default: s_nxt.pslverr = 1'b1;
      endcase
      if (!rd)
        s_nxt.prdata = 32'h0000_0000;
    end
    // writes land at the access edge to keep one register bank update per transfer
    if (psel && penable && s_r.pready && pwrite && !s_r.pslverr)
    begin
      case (paddr)
        `BKR_OFS_CTRL: s_nxt.ctrl = pwdata & `BKR_MSK_CTRL;
        `BKR_OFS_FREQ: s_nxt.freq = pwdata & `BKR_MSK_FREQ;
        `BKR_OFS_FMAX: s_nxt.fmax = pwdata & `BKR_MSK_FMAX;
        `BKR_OFS_CURR: s_nxt.curr = pwdata & `BKR_MSK_CURR;
        `BKR_OFS_TSTOP: s_nxt.tstop = pwdata & `BKR_MSK_TIME;
        `BKR_OFS_TSTART: s_nxt.tstart = pwdata & `BKR_MSK_TIME;
        `BKR_OFS_TMISC: s_nxt.tmisc = pwdata & `BKR_MSK_TIME;
        `BKR_OFS_DIFN0: s_nxt.difn0 = pwdata & `BKR_MSK_DIFN;
        `BKR_OFS_DIFN1: s_nxt.difn1 = pwdata & `BKR_MSK_DIFN;
        `BKR_OFS_AIFN: s_nxt.aifn = pwdata & `BKR_MSK_AIFN;
        default: s_nxt.pslverr = 1'b0;
      endcase
    end
    if (wr && 1'b0)
      s_nxt.pslverr = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.st <= BKR_IDLE;
      s_r.after_bb <= BKR_IDLE;
      s_r.baseblock <= 1'b1;
      s_r.fmax <= `BKR_RST_FMAX;
      s_r.curr <= `BKR_RST_CURR;
      s_r.tmisc <= `BKR_RST_TMISC;
    end
    else
      s_r <= s_nxt;
  end
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign baseblock = s_r.baseblock;
  assign dc_brake = s_r.dc_brake;
  assign sc_brake = s_r.sc_brake;
  assign dc_level = s_r.dc_level;
  assign sc_level = s_r.sc_level;
  assign run_enable = s_r.run_enable;
  assign speed_search = s_r.speed_search;
  assign start_at_min = s_r.start_at_min;
  assign ramp_ticks = s_r.ramp_ticks;
endmodule // bkr_seq

// ==== verification/bkr_seq_checker.sv ====
// port assertions for the braking sequencer
`timescale 1ns/1ns
`include "bkr_defs.svh"
module bkr_seq_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dc_brake,
  input wire logic sc_brake,
  input wire logic [7:0] dc_level,
  input wire logic [11:0] sc_level,
  input wire logic run_enable
);
  // ==========================================
  // sequences and properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence brake_on;
    dc_brake || sc_brake;
  endsequence
  pready_timing_a: assert property (apb_setup |=> pready && penable) else $error("no pready after setup");
  pready_idle_a: assert property (!psel |=> !pready) else $error("pready without select");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr outside access");
  rdata_quiet_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero");
  dc_level_max_a: assert property (dc_level <= `BKR_DC_MAX) else $error("dc level above range");
  sc_level_max_a: assert property (sc_level <= `BKR_SC_MAX) else $error("sc level above range");
  brake_phases_excl_a: assert property (!(dc_brake && sc_brake)) else $error("both brakes on");
  brake_no_run_a: assert property (brake_on |-> !run_enable) else $error("brake while running");
  dc_current_set_a: assert property ($rose(dc_brake) |-> dc_level != 8'h00) else $error("dc brake at zero");
endmodule // bkr_seq_checker

bind bkr_seq bkr_seq_checker chk
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .dc_brake(dc_brake),
  .sc_brake(sc_brake),
  .dc_level(dc_level),
  .sc_level(sc_level),
  .run_enable(run_enable)
);

// ==== verification/bkr_motor_model.sv ====
// behavioural power stage and motor feeding back output frequency
`timescale 1ns/1ns
module bkr_motor_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run_cmd,
  input wire logic run_enable,
  input wire logic dc_brake,
  input wire logic sc_brake,
  output logic [15:0] out_freq
);
  // ==========================================
  // ramp one step a cycle; braking stops the shaft at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_freq <= 16'h0000;
    else if (dc_brake || sc_brake)
      out_freq <= 16'h0000;
    else if (run_enable && run_cmd && out_freq < 16'h012C)
      out_freq <= out_freq + 16'h0001;
    else if (run_enable && !run_cmd && out_freq != 16'h0000)
      out_freq <= out_freq - 16'h0001;
  end
endmodule // bkr_motor_model

// ==== verification/stop_and_braking_sequencer_test.sv ====
// self-checking bench for the braking sequencer
`timescale 1ns/1ns
`include "bkr_defs.svh"
module stop_and_braking_sequencer_test;
  import bkr_pkg::*;
  localparam int TICK = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run_pin;
  logic baseblock, dc_brake, sc_brake, run_enable, speed_search, start_at_min;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] di_pin, dc_level;
  logic [15:0] out_freq;
  logic [11:0] sc_level;
  logic [23:0] ramp_ticks;
  logic [9:0] ai_code;
  int n_mismatch = 0;
  int tests_run = 0;
  bkr_seq #(.TICK_CYCLES(TICK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_pin(run_pin), .di_pin(di_pin), .out_freq(out_freq), .ai1_code(ai_code), .ai2_code(10'h000),
    .baseblock(baseblock), .dc_brake(dc_brake), .sc_brake(sc_brake), .dc_level(dc_level),
    .sc_level(sc_level), .run_enable(run_enable), .speed_search(speed_search),
    .start_at_min(start_at_min), .ramp_ticks(ramp_ticks));
  bkr_motor_model motor (.pclk(pclk), .presetn(presetn), .run_cmd(run_pin), .run_enable(run_enable),
    .dc_brake(dc_brake), .sc_brake(sc_brake), .out_freq(out_freq));
  // ==========================================
  // shared tasks
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang();
    n_mismatch++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    give_verdict();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
      hang();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // counts cycles until s equals v; a bound that runs out ends the run
  task automatic wait_bit(ref logic s, input logic v, input int lim, output int n);
    for (n = 0; n < lim && s !== v; n++)
      @(posedge pclk);
    if (n == lim)
      hang();
  endtask
  task automatic run_then_stop();
    int n;
    run_pin <= 1'b1;
    wait_bit(run_enable, 1'b1, 100, n);
    repeat (350) @(posedge pclk);
    run_pin <= 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    apb(1'b0, `BKR_OFS_FMAX, 32'h0000_0000, q, e);
    chk(q, `BKR_RST_FMAX);
    apb(1'b0, `BKR_OFS_CURR, 32'h0000_0000, q, e);
    chk(q, `BKR_RST_CURR);
    apb(1'b0, `BKR_OFS_TMISC, 32'h0000_0000, q, e);
    chk(q, `BKR_RST_TMISC);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    apb(1'b0, `BKR_OFS_STAT, 32'h0000_0000, q, e);
    chk({31'h0, q[10]}, 32'h0000_0001);
    chk({31'h0, start_at_min}, 32'h0000_0001); // no start braking
    $display("test reset done");
  endtask
  task automatic t_decel();
    int n;
    wr(`BKR_OFS_FREQ, 32'h0032_000A);
    wr(`BKR_OFS_CURR, 32'h0000_5064);
    wr(`BKR_OFS_TSTOP, 32'h0000_0005);
    run_then_stop();
    wait_bit(dc_brake, 1'b1, 2000, n);
    chk({31'h0, out_freq <= 16'h0032 && out_freq > 16'h0028}, 32'h0000_0001); // minimum wins
    chk({24'h0, dc_level}, 32'h0000_0050); // clamp to motor
    chk({31'h0, run_enable}, 32'h0000_0000); // ramp then brake
    wait_bit(dc_brake, 1'b0, 200, n);
    chk({31'h0, n >= 5 * TICK - 2 && n <= 6 * TICK + 2}, 32'h0000_0001); // stop brake time
    wait_bit(baseblock, 1'b1, 5, n);
    $display("test decel stop done");
  endtask
  task automatic t_zero_time();
    int n;
    int seen;
    seen = 0;
    wr(`BKR_OFS_TSTOP, 32'h0000_0000);
    run_then_stop();
    for (n = 0; n < 2000 && baseblock !== 1'b1; n++)
    begin
      @(posedge pclk);
      seen = seen | int'(dc_brake === 1'b1);
    end
    chk(seen, 32'h0000_0000); // zero disables
    chk({31'h0, baseblock}, 32'h0000_0001); // phase skipped
    $display("test zero stop time done");
  endtask
  task automatic t_terminal();
    int n;
    wr(`BKR_OFS_DIFN0, 32'h0000_0021);
    di_pin <= 8'h01;
    wait_bit(dc_brake, 1'b1, 20, n);
    chk({24'h0, dc_level}, 32'h0000_0050); // terminal brake
    di_pin <= 8'h00;
    wait_bit(dc_brake, 1'b0, 20, n);
    $display("test terminal brake done");
  endtask
  task automatic t_dc_stop();
    int n;
    wr(`BKR_OFS_TSTOP, 32'h0000_0005);
    wr(`BKR_OFS_TMISC, 32'h0064_0001);
    wr(`BKR_OFS_CTRL, 32'h0000_0020);
    run_then_stop();
    wait_bit(baseblock, 1'b1, 10, n);
    chk({31'h0, dc_brake}, 32'h0000_0000); // block first
    wait_bit(dc_brake, 1'b1, 200, n);
    chk({31'h0, n >= 9 * TICK && n <= 12 * TICK + 5}, 32'h0000_0001); // after baseblock time
    wait_bit(dc_brake, 1'b0, 600, n);
    chk({31'h0, n >= 235 && n <= 272}, 32'h0000_0001); // scaled brake time
    $display("test dc braking stop done");
  endtask
  task automatic t_analog();
    wr(`BKR_OFS_AIFN, 32'h0000_0005);
    ai_code <= 10'h200;
    repeat (3) @(posedge pclk);
    chk({24'h0, dc_level}, 32'h0000_0032); // analog current
    ai_code <= 10'h000;
    wr(`BKR_OFS_AIFN, 32'h0000_0000);
    $display("test analog current done");
  endtask
  task automatic t_pm();
    int n;
    wr(`BKR_OFS_CTRL, 32'h0000_0025);
    wr(`BKR_OFS_CURR, 32'h0FA0_5064);
    wr(`BKR_OFS_TSTART, 32'h0003_0002);
    wr(`BKR_OFS_TSTOP, 32'h0004_0005);
    @(posedge pclk);
    chk({31'h0, start_at_min}, 32'h0000_0000); // start braking on
    chk({20'h0, sc_level}, 32'h0000_07D0); // limit clamp
    run_pin <= 1'b1;
    wait_bit(sc_brake, 1'b1, 20, n);
    chk({31'h0, dc_brake}, 32'h0000_0000); // short-circuit first
    wait_bit(dc_brake, 1'b1, 100, n);
    chk({31'h0, sc_brake}, 32'h0000_0000); // then dc brake
    run_then_stop();
    chk({8'h0, ramp_ticks}, 32'h0000_01F4); // scaled decel time
    wait_bit(sc_brake, 1'b1, 2000, n);
    chk({31'h0, baseblock}, 32'h0000_0000); // decel, not baseblock
    wait_bit(dc_brake, 1'b1, 100, n);
    chk({31'h0, sc_brake}, 32'h0000_0000); // then dc brake
    wait_bit(dc_brake, 1'b0, 200, n);
    $display("test pm braking done");
  endtask
  // ==========================================
  // clock, reset and main sequence
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    run_pin = 1'b0;
    di_pin = 8'h00;
    ai_code = 10'h000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_decel();
    t_zero_time();
    t_terminal();
    t_analog();
    t_dc_stop();
    t_pm();
    give_verdict();
  end
endmodule // stop_and_braking_sequencer_test
